// ---- csb_pkg.sv ----
// Shared constants, types and helpers for the channel status buffer.
package csb_pkg;

    // Block geometry.
    localparam int CSB_WORDS  = 24;
    localparam int CSB_FRAMES = 192;
    localparam int CSB_RSV_W  = 5;

    // Register byte offsets on the APB.
    localparam logic [7:0] CSB_REG_CTRL = 8'h00;
    localparam logic [7:0] CSB_REG_STAT = 8'h04;
    localparam logic [7:0] CSB_REG_IEN  = 8'h08;
    localparam logic [7:0] CSB_REG_PTR  = 8'h0c;
    localparam logic [7:0] CSB_REG_DATA = 8'h10;

    // Control field positions, all reset to zero.
    localparam int CSB_C_INH_D2E = 0;
    localparam int CSB_C_INH_E2F = 1;
    localparam int CSB_C_RSV     = 2;
    localparam int CSB_C_TWO     = 3;
    localparam int CSB_C_SEL_B   = 4;
    localparam logic [4:0] CSB_CTRL_RST = 5'h00;

    // Status and enable field positions.
    localparam int CSB_S_D2E = 0;
    localparam int CSB_S_E2F = 1;

    // CRCC generator: polynomial low terms and preset.
    localparam logic [7:0] CSB_CRC_POLY = 8'h1d;
    localparam logic [7:0] CSB_CRC_INIT = 8'hff;

    typedef logic [CSB_WORDS-1:0][15:0] csb_blk_t;

    // Received frame: one status bit per subframe.
    typedef struct packed {
        logic strobe;
        logic blk_start;
        logic bit_a;
        logic bit_b;
    } csb_rx_t;

    // Transmitter request for the next frame's bits.
    typedef struct packed {
        logic strobe;
        logic blk_start;
    } csb_txreq_t;

    // Bits handed to the transmitter.
    typedef struct packed {
        logic valid;
        logic bit_a;
        logic bit_b;
    } csb_txbit_t;

    // Word index holding a frame's bit.
    function automatic logic [4:0] csb_word(input logic [7:0] fr);
        csb_word = fr[7:3];
    endfunction : csb_word

    // Bit within the channel byte; earliest bit is the MSB.
    function automatic logic [2:0] csb_bit(input logic [7:0] fr);
        csb_bit = 3'h7 - fr[2:0];
    endfunction : csb_bit

endpackage : csb_pkg

// ---- csb_crcc.sv ----
// Combinational CRCC over the first 23 bytes of one channel block.
`timescale 1ns/1ps
`default_nettype none
module csb_crcc (
    input  wire logic [183:0] data,
    output logic [7:0]        crc
);
    import csb_pkg::*;

    // Serial LFSR unrolled over all bits, earliest bit at the top.
    // It is wide logic, but it only has to settle once per block.
    always_comb begin
        logic fb;
        fb  = 1'b0;
        crc = CSB_CRC_INIT;
        for (int i = 183; i >= 0; i--) begin
            fb  = crc[7] ^ data[i];
            crc = {crc[6:0], 1'b0} ^ (fb ? CSB_CRC_POLY : 8'h00);
        end
    end

endmodule : csb_crcc
`default_nettype wire

// ---- csb_capture.sv ----
// Receive-capture buffer that assembles incoming status blocks.
`timescale 1ns/1ps
`default_nettype none
module csb_capture (
    input  wire logic          core_clk,
    input  wire logic          arst_n,
    input  wire csb_pkg::csb_rx_t rx,
    output csb_pkg::csb_blk_t  blk,
    output logic               done
);
    import csb_pkg::*;

    logic [7:0] cnt;  // Next frame number expected.
    logic [7:0] fr;   // Frame number of the current strobe.

    // A block start forces frame zero; a lost start wraps anyway.
    assign fr = (rx.blk_start || cnt == 8'(CSB_FRAMES)) ? 8'h00 : cnt;

    // Drop each received bit into its slot, both channels.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            blk <= '0;
            cnt <= 8'h00;
        end else if (rx.strobe) begin
            blk[csb_word(fr)][8 + csb_bit(fr)] <= rx.bit_a;
            blk[csb_word(fr)][csb_bit(fr)]     <= rx.bit_b;
            cnt <= fr + 8'h01;
        end
    end

    // Completion pulse in the cycle after the last bit lands.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
        end else begin
            done <= rx.strobe && fr == 8'(CSB_FRAMES - 1);
        end
    end

endmodule : csb_capture
`default_nettype wire

// ---- csb_buffer.sv ----
// Channel status block buffer cascade with APB host access.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module csb_buffer (
    input  wire logic           core_clk,
    input  wire logic           arst_n,
    // APB slave.
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Receiver side.
    input  wire csb_pkg::csb_rx_t rx,
    // Transmitter side.
    input  wire csb_pkg::csb_txreq_t tx_req,
    output csb_pkg::csb_txbit_t tx_out,
    // Copy event output.
    output logic                irq
);
    import csb_pkg::*;

    // Register state.
    logic [4:0]  ctrl;       // Inhibits, reserve, width and channel select.
    logic [1:0]  stat;       // Sticky copy flags.
    logic [1:0]  ien;        // Copy event enables.
    logic [4:0]  ptr;        // Host word pointer.
    logic        phase;      // Second byte pending in two-byte mode.
    logic [7:0]  hold_a;     // Channel A byte awaiting its partner.

    // The three buffers.
    csb_blk_t    d_blk;      // Capture buffer contents.
    csb_blk_t    e_blk;      // Host buffer, both channel blocks.
    csb_blk_t    f_blk;      // Transmit source buffer.
    csb_blk_t    e_crc;      // Host buffer with CRCC patched in.

    // Copy strobes and transfer decode.
    logic        d_done;     // Capture block complete.
    logic        d2e_go;     // Capture-to-host copy this cycle.
    logic        e2f_go;     // Host-to-transmit copy this cycle.
    logic        setup;      // APB setup phase.
    logic        acc;        // APB access phase.
    logic        wr;         // Write takes effect.
    logic        rd;         // Read completes.
    logic        mapped;     // Address hits a register.
    logic        data_hit;   // Access to the buffer window.
    logic        advance;    // Pointer moves on this access.
    logic [7:0]  wbyte;      // Written byte.
    logic [7:0]  crc_a;      // CRCC for channel A.
    logic [7:0]  crc_b;      // CRCC for channel B.
    logic [183:0] str_a;     // Channel A bytes 0..22 in send order.
    logic [183:0] str_b;     // Channel B bytes 0..22 in send order.

    // Transmit side.
    logic [7:0]  tcnt;       // Next transmit frame number.
    logic [7:0]  tfr;        // Frame number of this request.
    csb_blk_t    t_src;      // Block the bits come from.

    // Capture buffer builds blocks from the receiver.
    csb_capture u_cap (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .rx       (rx),
        .blk      (d_blk),
        .done     (d_done)
    );

    // Gather each channel's first 23 bytes for the CRCC.
    always_comb begin
        str_a = '0;
        str_b = '0;
        for (int i = 0; i < 23; i++) begin
            if (i % 2 == 0) begin
                str_a[183 - 8*i -: 8] = e_blk[i/2 + 12*0][15:8];
                str_b[183 - 8*i -: 8] = e_blk[i/2 + 12*0][7:0];
            end else begin
                str_a[183 - 8*i -: 8] = e_blk[i/2 + 12*0][15:8];
                str_b[183 - 8*i -: 8] = e_blk[i/2 + 12*0][7:0];
            end
        end
        // Bytes are held one per word, so index directly by byte.
        for (int i = 0; i < 23; i++) begin
            str_a[183 - 8*i -: 8] = e_blk[i][15:8];
            str_b[183 - 8*i -: 8] = e_blk[i][7:0];
        end
    end

    // One CRCC generator per channel.
    csb_crcc u_crc_a (
        .data (str_a),
        .crc  (crc_a)
    );

    csb_crcc u_crc_b (
        .data (str_b),
        .crc  (crc_b)
    );

    // Patch the last byte of any professional channel block.
    // Each channel is judged by its own first bit.
    always_comb begin
        e_crc = e_blk;
        if (e_blk[0][15]) begin
            e_crc[CSB_WORDS-1][15:8] = crc_a;
        end
        if (e_blk[0][7]) begin
            e_crc[CSB_WORDS-1][7:0] = crc_b;
        end
    end

    // Copies fire on block boundaries unless inhibited.
    assign d2e_go = d_done && !ctrl[CSB_C_INH_D2E];
    assign e2f_go = tx_req.strobe && tx_req.blk_start
                    && !ctrl[CSB_C_INH_E2F];

    // APB decode; the slave never inserts wait states.
    assign setup    = psel && !penable;
    assign acc      = psel && penable;
    assign wr       = acc && pwrite;
    assign rd       = acc && !pwrite;
    assign pready   = 1'b1;
    assign mapped   = paddr == CSB_REG_CTRL || paddr == CSB_REG_STAT
                   || paddr == CSB_REG_IEN  || paddr == CSB_REG_PTR
                   || paddr == CSB_REG_DATA;
    assign pslverr  = acc && !mapped;
    assign data_hit = acc && paddr == CSB_REG_DATA;
    assign wbyte    = pwdata[7:0];

    // The pointer moves after each full word in two-byte mode
    // and after every byte in one-byte mode.
    assign advance  = data_hit && (!ctrl[CSB_C_TWO] || phase);

    // Control and enable registers.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= CSB_CTRL_RST;
            ien  <= 2'h0;
        end else if (wr && paddr == CSB_REG_CTRL) begin
            ctrl <= pwdata[4:0];
        end else if (wr && paddr == CSB_REG_IEN) begin
            ien  <= pwdata[1:0];
        end
    end

    // Word pointer and byte phase. A pointer write, or a change
    // of access width, restarts the byte pairing on channel A.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr   <= 5'h00;
            phase <= 1'b0;
        end else if (wr && paddr == CSB_REG_PTR) begin
            ptr   <= (pwdata[4:0] < 5'(CSB_WORDS)) ? pwdata[4:0] : 5'h00;
            phase <= 1'b0;
        end else if (wr && paddr == CSB_REG_CTRL) begin
            phase <= 1'b0;
        end else if (data_hit) begin
            phase <= ctrl[CSB_C_TWO] && !phase;
            if (advance) begin
                ptr <= (ptr == 5'(CSB_WORDS - 1)) ? 5'h00 : ptr + 5'h01;
            end
        end
    end

    // Channel A byte is held until the B byte completes the word.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_a <= 8'h00;
        end else if (wr && data_hit && ctrl[CSB_C_TWO] && !phase) begin
            hold_a <= wbyte;
        end
    end

    // Host buffer: block copies first, then a host write on top,
    // so a write landing in the copy cycle is never lost.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            e_blk <= '0;
        end else begin
            if (d2e_go) begin
                for (int i = 0; i < CSB_WORDS; i++) begin
                    if (!(ctrl[CSB_C_RSV] && i < CSB_RSV_W)) begin
                        e_blk[i] <= d_blk[i];
                    end
                end
            end
            if (wr && data_hit) begin
                if (!ctrl[CSB_C_TWO]) begin
                    e_blk[ptr] <= {wbyte, wbyte};
                end else if (phase) begin
                    e_blk[ptr] <= {hold_a, wbyte};
                end
            end
        end
    end

    // Transmit buffer takes the whole host block at a block start.
    // A block copied twice is simply sent twice, and a block that
    // was overwritten before a start is never sent.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            f_blk <= '0;
        end else if (e2f_go) begin
            f_blk <= e_crc;
        end
    end

    // Sticky copy flags: write one to clear, a new copy wins.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat <= 2'h0;
        end else begin
            if (wr && paddr == CSB_REG_STAT) begin
                stat <= stat & ~pwdata[1:0];
            end
            if (d2e_go) begin
                stat[CSB_S_D2E] <= 1'b1;
            end
            if (e2f_go) begin
                stat[CSB_S_E2F] <= 1'b1;
            end
        end
    end

    // Event output, gated by the enables.
    assign irq = |(stat & ien);

    // Read data is fetched in the setup phase, ready at the access.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                CSB_REG_CTRL: prdata <= {27'h0, ctrl};
                CSB_REG_STAT: prdata <= {30'h0, stat};
                CSB_REG_IEN:  prdata <= {30'h0, ien};
                CSB_REG_PTR:  prdata <= {26'h0, phase, ptr};
                CSB_REG_DATA: begin
                    if (ctrl[CSB_C_TWO]) begin
                        prdata <= {24'h0, phase ? e_blk[ptr][7:0]
                                                : e_blk[ptr][15:8]};
                    end else begin
                        prdata <= {24'h0, ctrl[CSB_C_SEL_B] ? e_blk[ptr][7:0]
                                                           : e_blk[ptr][15:8]};
                    end
                end
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Transmit frame number; a block start forces frame zero.
    assign tfr   = (tx_req.blk_start || tcnt == 8'(CSB_FRAMES)) ? 8'h00 : tcnt;

    // The first frame of a block already reads the newly copied data.
    assign t_src = e2f_go ? e_crc : f_blk;

    // Serial bits handed to the transmitter, one pair per frame.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tcnt   <= 8'h00;
            tx_out <= '0;
        end else begin
            tx_out.valid <= tx_req.strobe;
            if (tx_req.strobe) begin
                tx_out.bit_a <= t_src[csb_word(tfr)][8 + csb_bit(tfr)];
                tx_out.bit_b <= t_src[csb_word(tfr)][csb_bit(tfr)];
                tcnt         <= tfr + 8'h01;
            end
        end
    end

endmodule : csb_buffer
`default_nettype wire

// ---- csb_buffer_properties.sv ----
// Concurrent checks on the top ports of the channel status buffer.
`timescale 1ns/1ps
`default_nettype none
module csb_buffer_properties (
    input wire logic                core_clk,
    input wire logic                arst_n,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire csb_pkg::csb_rx_t    rx,
    input wire csb_pkg::csb_txreq_t tx_req,
    input wire csb_pkg::csb_txbit_t tx_out,
    input wire logic                irq
);
    import csb_pkg::*;
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic mapped; // High when the address hits one of the five registers.
    assign mapped = paddr inside {CSB_REG_CTRL, CSB_REG_STAT, CSB_REG_IEN, CSB_REG_PTR, CSB_REG_DATA};
    sequence s_acc; psel && penable; endsequence
    sequence s_tx_req; tx_req.strobe; endsequence
    sequence s_tx_ans; tx_out.valid; endsequence
    a_ready_access: assert property (s_acc |-> pready)
        else $error("pready low in an access cycle");
    a_slverr_unmapped: assert property ((s_acc ##0 !mapped) |-> pslverr)
        else $error("unmapped access without pslverr");
    a_slverr_mapped: assert property ((s_acc ##0 mapped) |-> !pslverr)
        else $error("pslverr on a mapped register");
    // Read data may only move at the edge that takes a read setup.
    a_rdata_holds: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
        else $error("prdata moved without a read");
    a_tx_answer: assert property (s_tx_req |=> s_tx_ans)
        else $error("no valid one cycle after request");
    a_tx_cause: assert property (s_tx_ans |-> $past(tx_req.strobe))
        else $error("valid without a request");
    a_tx_bits_hold: assert property (!$past(tx_req.strobe) |-> $stable({tx_out.bit_a, tx_out.bit_b}))
        else $error("transmit bits changed between requests");
    // Events come from a register write, a block start or a finished block.
    a_irq_cause: assert property ($rose(irq) |-> $past(psel && penable && pwrite)
        || $past(tx_req.strobe && tx_req.blk_start) || $past(rx.strobe, 2))
        else $error("irq rose without a copy or write");
endmodule : csb_buffer_properties
bind csb_buffer csb_buffer_properties csb_buffer_properties_i (.core_clk(core_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
    .tx_req(tx_req), .tx_out(tx_out), .irq(irq));
`default_nettype wire

// ---- csb_link_model.sv ----
// Receiver and transmitter stand-in that feeds and drains status frames.
`timescale 1ns/1ps
`default_nettype none
module csb_link_model (
    input wire logic                core_clk,
    input wire logic                rx_go,
    input wire logic                tx_go,
    input wire logic [2:0]          gap,
    input wire csb_pkg::csb_blk_t   rx_blk,
    output var csb_pkg::csb_rx_t    rx,
    output var csb_pkg::csb_txreq_t tx_req,
    output var logic                busy
);
    import csb_pkg::*;
    initial begin
        rx = '0;
        tx_req = '0;
        busy = 1'b0;
    end
    // One whole block per go pulse; gap makes the far side slow or prompt.
    always begin : run
        bit is_tx;
        @(posedge core_clk);
        is_tx = tx_go;
        if (tx_go || rx_go) begin
            busy <= 1'b1;
            for (int f = 0; f < CSB_FRAMES; f++) begin
                if (is_tx) begin
                    tx_req <= '{1'b1, f == 0};
                end else begin
                    rx <= '{1'b1, f == 0, rx_blk[f/8][15-f%8], rx_blk[f/8][7-f%8]};
                end
                @(posedge core_clk);
                // Back-to-back requests keep the strobe up rather than dropping
                // and raising it in one time step.
                if (!is_tx || gap != 3'h0 || f == CSB_FRAMES - 1) begin
                    tx_req <= '0;
                    // Idle data lines toggle so a stale bit is never mistaken for data.
                    rx <= '{1'b0, 1'b0, ~rx.bit_a, ~rx.bit_b};
                end
                repeat (is_tx ? gap : gap + 1) @(posedge core_clk);
            end
            busy <= 1'b0;
        end
    end
endmodule : csb_link_model
`default_nettype wire

// ---- csb_buffer_tb_top.sv ----
// Self-checking bench for the channel status block buffer.
`timescale 1ns/1ps
`default_nettype none
module csb_buffer_tb_top;
    import csb_pkg::*;
    logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        rx_go, tx_go, busy;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0]  gap;
    csb_rx_t     rx;
    csb_txreq_t  tx_req;
    csb_txbit_t  tx_out;
    csb_blk_t    hb, rx_blk, txb; // Host shadow, next received block, sent block.
    logic [31:0] rd_q[$];         // Expected read data, oldest first.
    logic [1:0]  tx_q[$];         // Expected A and B bits per sent frame.
    int          num_errors, n_tests;

    csb_buffer csb_buffer_i (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
        .tx_req(tx_req), .tx_out(tx_out), .irq(irq));
    csb_link_model csb_link_model_i (.core_clk(core_clk), .rx_go(rx_go), .tx_go(tx_go),
        .gap(gap), .rx_blk(rx_blk), .rx(rx), .tx_req(tx_req), .busy(busy));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Missing results count as errors before the verdict.
    task automatic summarize;
        // Let the compare processes take the last results first.
        repeat (2) @(posedge core_clk);
        if (rd_q.size() + tx_q.size() != 0) begin
            $display("mismatch at %0t: results missing", $time);
            num_errors++;
        end
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    task automatic timed_out;
        $display("mismatch at %0t: wait ran out", $time);
        num_errors++;
        summarize();
    endtask : timed_out

    // One APB transfer, held until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) timed_out();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Event output level against what the copy flags should show.
    task automatic chk_irq(input logic e);
        n_tests++;
        if (irq !== e) begin
            $display("mismatch at %0t: irq is %b", $time, irq);
            num_errors++;
        end
    endtask : chk_irq

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Two-byte write of one word, A byte first.
    task automatic put_w(input int i, input logic [15:0] v);
        apb(1'b1, CSB_REG_DATA, {24'h0, v[15:8]});
        apb(1'b1, CSB_REG_DATA, {24'h0, v[7:0]});
        hb[i] = v;
    endtask : put_w

    task automatic chk_all;
        apb(1'b1, CSB_REG_PTR, 32'h0);
        for (int i = 0; i < CSB_WORDS; i++) begin
            rd(CSB_REG_DATA, {24'h0, hb[i][15:8]});
            rd(CSB_REG_DATA, {24'h0, hb[i][7:0]});
        end
    endtask : chk_all

    // Check byte, earliest bit first, over bytes 0 to 22 of one channel.
    function automatic logic [7:0] crc_of(input csb_blk_t b, input int sh);
        logic [7:0] c;
        logic       fb;
        c = CSB_CRC_INIT;
        for (int i = 0; i < 184; i++) begin
            fb = c[7] ^ b[i/8][sh+7-i%8];
            c = {c[6:0], 1'b0} ^ (fb ? CSB_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc_of

    task automatic exp_tx(input csb_blk_t b);
        if (b[0][15]) b[23][15:8] = crc_of(b, 8);
        if (b[0][7]) b[23][7:0] = crc_of(b, 0);
        for (int f = 0; f < CSB_FRAMES; f++) tx_q.push_back({b[f/8][15-f%8], b[f/8][7-f%8]});
    endtask : exp_tx

    // Start one block at the far side and wait, bounded, until it is done.
    task automatic run(input logic is_tx);
        int i;
        gap <= 3'($urandom_range(0, 3));
        if (is_tx) tx_go <= 1'b1;
        else rx_go <= 1'b1;
        @(posedge core_clk);
        tx_go <= 1'b0;
        rx_go <= 1'b0;
        @(posedge core_clk);
        for (i = 0; i < 2000 && busy; i++) @(posedge core_clk);
        if (i == 2000) timed_out();
    endtask : run

    // Read results are compared at the edge that ends the access.
    always @(posedge core_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
            n_tests++;
            if (rd_q.size() == 0 || prdata !== rd_q[0]) begin
                $display("mismatch at %0t: read data %h", $time, prdata);
                num_errors++;
            end
            if (rd_q.size() != 0) void'(rd_q.pop_front());
        end
    end

    // Every transmitted frame is compared with the oldest note.
    always @(posedge core_clk) begin
        if (tx_out.valid === 1'b1) begin
            n_tests++;
            if (tx_q.size() == 0 || {tx_out.bit_a, tx_out.bit_b} !== tx_q[0]) begin
                $display("mismatch at %0t: transmit bits", $time);
                num_errors++;
            end
            if (tx_q.size() != 0) void'(tx_q.pop_front());
        end
    end

    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, rx_go, tx_go} = '0;
        {paddr, pwdata, gap, rx_blk, hb, txb} = '0;
        num_errors = 0;
        n_tests = 0;
        void'($urandom(67));
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, then an unmapped word that reads zero.
        for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0);
        // One-byte writes fill both halves; reads pick A or B and wrap.
        // An out-of-range pointer lands on word zero, undoing the reset reads' step.
        apb(1'b1, CSB_REG_PTR, 32'h1e);
        rd(CSB_REG_PTR, 32'h0);
        for (int i = 0; i < CSB_WORDS; i++) begin
            logic [7:0] v;
            v = 8'($urandom) & (i == 0 ? 8'h7f : 8'hff);
            apb(1'b1, CSB_REG_DATA, {24'h0, v});
            hb[i] = {v, v};
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, CSB_REG_CTRL, 32'(s << CSB_C_SEL_B));
            apb(1'b1, CSB_REG_PTR, 32'h0);
            for (int i = 0; i < 25; i++) rd(CSB_REG_DATA, {24'h0, hb[i%24][15:8]});
        end
        apb(1'b1, CSB_REG_CTRL, 32'h08);
        apb(1'b1, CSB_REG_PTR, 32'h0);
        for (int i = 0; i < CSB_WORDS; i++) put_w(i, 16'($urandom) & (i == 0 ? 16'h7f7f : 16'hffff));
        chk_all();
        // Copy into the transmitter, then repeat the old block while inhibited.
        apb(1'b1, CSB_REG_IEN, 32'h3);
        txb = hb;
        exp_tx(txb);
        run(1'b1);
        rd(CSB_REG_STAT, 32'h2);
        chk_irq(1'b1);
        apb(1'b1, CSB_REG_STAT, 32'h3);
        apb(1'b1, CSB_REG_CTRL, 32'h0a);
        put_w(0, 16'h1234);
        exp_tx(txb);
        run(1'b1);
        rd(CSB_REG_STAT, 32'h0);
        // Professional flag in both channels brings the computed check byte.
        apb(1'b1, CSB_REG_CTRL, 32'h08);
        apb(1'b1, CSB_REG_PTR, 32'h0);
        put_w(0, hb[0] | 16'h8080);
        exp_tx(hb);
        run(1'b1);
        // Capture with the first five words reserved for the host.
        apb(1'b1, CSB_REG_STAT, 32'h3);
        apb(1'b1, CSB_REG_CTRL, 32'h0c);
        for (int i = 0; i < CSB_WORDS; i++) rx_blk[i] = 16'($urandom);
        run(1'b0);
        for (int i = CSB_RSV_W; i < CSB_WORDS; i++) hb[i] = rx_blk[i];
        rd(CSB_REG_STAT, 32'h1);
        chk_all();
        // An inhibited capture leaves the host buffer untouched.
        apb(1'b1, CSB_REG_STAT, 32'h3);
        apb(1'b1, CSB_REG_CTRL, 32'h09);
        rx_blk = ~rx_blk;
        run(1'b0);
        rd(CSB_REG_STAT, 32'h0);
        chk_irq(1'b0);
        chk_all();
        summarize();
    end
endmodule : csb_buffer_tb_top
`default_nettype wire
